// ### dbr_cfg.svh
// Constants for the debug enclave read block: register offsets, field positions,
// page type codes, the read leaf, the thread page limit and the slot mask.
// Assumes it is included by bare name from the package and the testbench.
`ifndef DBR_CFG_SVH
`define DBR_CFG_SVH

// Register byte offsets
`define DBR_OFF_CMD 8'h00
`define DBR_OFF_MODE 8'h04
`define DBR_OFF_SRC_LO 8'h08
`define DBR_OFF_SRC_HI 8'h0c
`define DBR_OFF_RES_LO 8'h10
`define DBR_OFF_RES_HI 8'h14
`define DBR_OFF_STATUS 8'h18

// Mode register fields
`define DBR_MODE_LMA_BIT 0
`define DBR_MODE_CSL_BIT 1
`define DBR_MODE_PRIV_LO 2

// Status register fields
`define DBR_STAT_BUSY_BIT 0
`define DBR_STAT_DONE_BIT 1
`define DBR_STAT_FAULT_LO 4
`define DBR_STAT_CODE_LO 8

// Leaf selector of the debug enclave read
`define DBR_LEAF_READ 8'h04

// Page type codes of the map entry
`define DBR_PT_CONTROL 3'h0
`define DBR_PT_THREAD 3'h1
`define DBR_PT_REGULAR 3'h2
`define DBR_PT_VERSION 3'h3

// Thread control page size limit (offset within page)
`define DBR_THREAD_LIMIT 12'h100

// Version array slot mask
`define DBR_VA_MASK 64'h0000000000000007

`endif

// ### dbr_pkg.sv
// Types shared by the debug enclave read block.
// Assumes dbr_cfg.svh is on the include path.
`default_nettype none
package dbr_pkg;
    `include "dbr_cfg.svh"

    typedef enum logic [1:0] {
        DBR_IDLE = 2'b00,
        DBR_FETCH = 2'b01
    } dbr_state_t;

    typedef enum logic [1:0] {
        DBR_FLT_NONE = 2'b00,
        DBR_FLT_GP = 2'b01,
        DBR_FLT_PF = 2'b10
    } dbr_fault_t;

    typedef enum logic [1:0] {
        DBR_ST_SUCCESS = 2'b00,
        DBR_ST_NOT_DEBUG = 2'b01,
        DBR_ST_FAULTED = 2'b10
    } dbr_code_t;
endpackage
`default_nettype wire

// ### dbr_check.sv
// Ordered validity checker of the debug enclave read.
// Assumes the map lookup answer is stable while it is evaluated.
`default_nettype none
module dbr_check
    import dbr_pkg::*;
(
    input wire logic long_mode,
    input wire logic [1:0] priv_level,
    input wire logic [11:0] src_low,
    input wire logic in_cache,
    input wire logic map_busy,
    input wire logic map_valid,
    input wire logic [2:0] page_type,
    input wire logic owner_debug,
    input wire logic page_pending,
    input wire logic page_modified,
    output dbr_fault_t pre_fault,
    output dbr_fault_t fault,
    output dbr_code_t code
);
    logic is_thread;
    logic is_reg;
    logic is_va;

    assign is_thread = (page_type == `DBR_PT_THREAD);
    assign is_reg = (page_type == `DBR_PT_REGULAR);
    assign is_va = (page_type == `DBR_PT_VERSION);

    // Checks that need no lookup: privilege, then alignment
    always_comb begin
        pre_fault = DBR_FLT_NONE;
        if (priv_level != 2'h0) begin
            pre_fault = DBR_FLT_GP;
        end else if (long_mode ? (src_low[2:0] != 3'h0) : (src_low[1:0] != 2'h0)) begin
            pre_fault = DBR_FLT_GP;
        end
    end

    // Lookup checks in their fixed order; the first failure wins.
    // Map permission bits never enter here, so they cannot fault.
    always_comb begin
        fault = DBR_FLT_NONE;
        code = DBR_ST_SUCCESS;
        if (pre_fault != DBR_FLT_NONE) begin
            fault = pre_fault;
        end else if (!in_cache) begin
            fault = DBR_FLT_PF;
        end else if (map_busy) begin
            fault = DBR_FLT_GP;
        end else if (!map_valid) begin
            fault = DBR_FLT_PF;
        end else if (!(is_thread || is_reg || is_va)) begin
            fault = DBR_FLT_PF;
        end else if (is_thread && (src_low >= `DBR_THREAD_LIMIT)) begin
            fault = DBR_FLT_GP;
        end else if ((is_thread || is_reg) && !owner_debug) begin
            fault = DBR_FLT_GP;
        end
        if (fault != DBR_FLT_NONE) begin
            code = DBR_ST_FAULTED;
        end else if (page_pending || page_modified) begin
            code = DBR_ST_NOT_DEBUG;
        end
    end
endmodule
`default_nettype wire

// ### dbr_top.sv
// Debug enclave read engine with an AHB-Lite register slave.
// Assumes a single AHB-Lite master, word transfers only, and a page cache
// port that answers each held request with one ack pulse carrying the
// map entry, the owner debug attribute and the 64-bit word.
`default_nettype none
module dbr_top
    import dbr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic pcm_req,
    output logic [63:0] pcm_addr,
    input wire logic pcm_ack,
    input wire logic pcm_in_cache,
    input wire logic pcm_map_busy,
    input wire logic pcm_valid,
    input wire logic [2:0] pcm_page_type,
    input wire logic pcm_pending,
    input wire logic pcm_modified,
    input wire logic pcm_owner_debug,
    input wire logic [63:0] pcm_data
);
    // Whole state of the block
    typedef struct packed {
        dbr_state_t state;
        logic dph;
        logic dph_write;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
        logic lma_flag;
        logic cs_long;
        logic [1:0] priv;
        logic [63:0] src;
        logic [63:0] result;
        logic busy;
        logic done;
        dbr_fault_t fault;
        dbr_code_t code;
        logic req;
    } dbr_regs_t;

    dbr_regs_t s_q;
    dbr_regs_t s_d;

    logic long_mode;
    logic start;
    logic is_read_leaf;
    logic [63:0] va_slot;
    logic [63:0] wide_word;
    dbr_fault_t pre_fault;
    dbr_fault_t chk_fault;
    dbr_code_t chk_code;

    // Register index decode, used by both the read and the write path
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    assign long_mode = s_q.lma_flag & s_q.cs_long;

    // Command writes are taken only when idle
    assign start = s_q.dph && s_q.dph_write && hit(s_q.dph_addr, `DBR_OFF_CMD) && !s_q.busy;
    assign is_read_leaf = (hwdata[7:0] == `DBR_LEAF_READ);

    assign va_slot = pcm_data & ~`DBR_VA_MASK;
    assign wide_word = (va_slot != 64'h0) ? {64{1'b1}} : 64'h0;

    dbr_check u_check (
        .long_mode(long_mode),
        .priv_level(s_q.priv),
        .src_low(s_q.src[11:0]),
        .in_cache(pcm_in_cache),
        .map_busy(pcm_map_busy),
        .map_valid(pcm_valid),
        .page_type(pcm_page_type),
        .owner_debug(pcm_owner_debug),
        .page_pending(pcm_pending),
        .page_modified(pcm_modified),
        .pre_fault(pre_fault),
        .fault(chk_fault),
        .code(chk_code)
    );

    // Next-state logic: bus slave, register writes and the read sequence
    always_comb begin
        s_d = s_q;

        // Address phase capture; zero wait states, so every phase is taken
        s_d.dph = hsel && hready && htrans[1];
        s_d.dph_write = hwrite;
        s_d.dph_addr = haddr[7:0];

        // Read data is latched at the address phase so hrdata comes from a flop.
        // A write and a read never overlap since the master idles between them.
        s_d.rdata = 32'h0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (hit(haddr[7:0], `DBR_OFF_MODE)) begin
                s_d.rdata = {28'h0, s_q.priv, s_q.cs_long, s_q.lma_flag};
            end else if (hit(haddr[7:0], `DBR_OFF_SRC_LO)) begin
                s_d.rdata = s_q.src[31:0];
            end else if (hit(haddr[7:0], `DBR_OFF_SRC_HI)) begin
                s_d.rdata = s_q.src[63:32];
            end else if (hit(haddr[7:0], `DBR_OFF_RES_LO)) begin
                s_d.rdata = s_q.result[31:0];
            end else if (hit(haddr[7:0], `DBR_OFF_RES_HI)) begin
                s_d.rdata = s_q.result[63:32];
            end else if (hit(haddr[7:0], `DBR_OFF_STATUS)) begin
                s_d.rdata = {22'h0, s_q.code, 2'h0, s_q.fault, 2'h0, s_q.done, s_q.busy};
            end
        end

        // Operand writes are ignored while busy so the lookup sees a stable address
        if (s_q.dph && s_q.dph_write && !s_q.busy) begin
            if (hit(s_q.dph_addr, `DBR_OFF_MODE)) begin
                s_d.lma_flag = hwdata[`DBR_MODE_LMA_BIT];
                s_d.cs_long = hwdata[`DBR_MODE_CSL_BIT];
                s_d.priv = hwdata[`DBR_MODE_PRIV_LO +: 2];
            end else if (hit(s_q.dph_addr, `DBR_OFF_SRC_LO)) begin
                s_d.src[31:0] = hwdata;
            end else if (hit(s_q.dph_addr, `DBR_OFF_SRC_HI)) begin
                s_d.src[63:32] = hwdata;
            end
        end

        // Done clears on write-one; a completion in the same cycle wins below
        if (s_q.dph && s_q.dph_write && hit(s_q.dph_addr, `DBR_OFF_STATUS)
            && hwdata[`DBR_STAT_DONE_BIT]) begin
            s_d.done = 1'b0;
        end

        case (s_q.state)
            DBR_IDLE: begin
                if (start) begin
                    if (!is_read_leaf) begin
                        // Unknown leaf ends at once as a general protection fault
                        s_d.fault = DBR_FLT_GP;
                        s_d.code = DBR_ST_FAULTED;
                        s_d.done = 1'b1;
                    end else if (pre_fault != DBR_FLT_NONE) begin
                        s_d.fault = pre_fault;
                        s_d.code = DBR_ST_FAULTED;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.busy = 1'b1;
                        s_d.req = 1'b1;
                        s_d.done = 1'b0;
                        s_d.fault = DBR_FLT_NONE;
                        s_d.code = DBR_ST_SUCCESS;
                        s_d.state = DBR_FETCH;
                    end
                end
            end
            DBR_FETCH: begin
                if (pcm_ack) begin
                    s_d.req = 1'b0;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.fault = chk_fault;
                    s_d.code = chk_code;
                    s_d.state = DBR_IDLE;
                    if (chk_code == DBR_ST_SUCCESS) begin
                        if (pcm_page_type == `DBR_PT_VERSION) begin
                            if (long_mode) begin
                                s_d.result = wide_word;
                            end else begin
                                s_d.result[31:0] = wide_word[31:0];
                            end
                        end else if (long_mode) begin
                            s_d.result = pcm_data;
                        end else begin
                            s_d.result[31:0] = pcm_data[31:0];
                        end
                    end
                end
            end
            default: begin
                s_d.state = DBR_IDLE;
                s_d.req = 1'b0;
                s_d.busy = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Bus answers: never stalls, always OKAY
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Page cache request holds the source address until acknowledged
    assign pcm_req = s_q.req;
    assign pcm_addr = s_q.src;
endmodule
`default_nettype wire

// ### dbr_chk.sv
// Checker of dbr_top bus answers and page cache port timing.
// Assumes one master with hready tied to hreadyout.
`default_nettype none
module dbr_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pcm_req,
    input wire logic [63:0] pcm_addr,
    input wire logic pcm_ack
);
    logic rd_q;
    logic wc_q;
    logic [7:0] ra_q;
    wire logic tk = hsel && hready && htrans[1];
    // Command write data phase carrying the read leaf
    wire logic leaf_wr = wc_q && hwdata[7:0] == 8'h04;
    // Track data phases; read data only stand one edge after the address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wc_q <= 1'b0;
            ra_q <= 8'h00;
        end else begin
            rd_q <= tk && !hwrite;
            wc_q <= tk && hwrite && haddr[7:0] == 8'h00;
            ra_q <= haddr[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence req_wait;
        pcm_req && !pcm_ack;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or not okay");
    req_hold_a: assert property (req_wait |=> pcm_req)
        else $error("page request dropped before ack");
    req_drop_a: assert property (pcm_req && pcm_ack |=> !pcm_req)
        else $error("page request held after ack");
    addr_hold_a: assert property (req_wait |=> $stable(pcm_addr))
        else $error("source address moved during request");
    leaf_start_a: assert property ($rose(pcm_req) |-> $past(leaf_wr))
        else $error("request without read leaf command");
    idle_zero_a: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    busy_stat_a: assert property (rd_q && ra_q == 8'h18 && $stable(pcm_req)
        |-> hrdata[0] == pcm_req)
        else $error("busy bit disagrees with request");
    unmap_zero_a: assert property (rd_q && (ra_q > 8'h18 || ra_q == 8'h00)
        |-> hrdata == 32'h0)
        else $error("unmapped or command read not zero");
endmodule
bind dbr_top dbr_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pcm_req(pcm_req), .pcm_addr(pcm_addr),
    .pcm_ack(pcm_ack));
`default_nettype wire

// ### testbench.sv
// Self-checking bench of dbr_top: AHB-Lite master and scripted page cache.
// Assumes dbr_cfg.svh, dbr_pkg and the design are compiled first.
`include "dbr_cfg.svh"
`default_nettype none
module testbench import dbr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // In cache, valid, debug owner, regular page
    localparam logic [8:0] OKR = 9'h162;
    localparam logic [63:0] D0 = 64'h0123456789abcdef;
    localparam logic [31:0] TL = 32'h1000 | `DBR_THREAD_LIMIT;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pcm_req, pcm_ack;
    logic pcm_in_cache, pcm_map_busy, pcm_valid, pcm_pending, pcm_modified, pcm_owner_debug;
    logic [1:0] htrans;
    logic [2:0] hsize, pcm_page_type;
    logic [31:0] haddr, hwdata, hrdata, hr_q, rv;
    logic [63:0] pcm_addr, pcm_data, res_m;
    int n_mismatch, total_checks, cyc;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    // Read data as it stood at the sampling edge
    always @(posedge hclk) hr_q <= hrdata;
    dbr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pcm_req(pcm_req),
        .pcm_addr(pcm_addr), .pcm_ack(pcm_ack), .pcm_in_cache(pcm_in_cache),
        .pcm_map_busy(pcm_map_busy), .pcm_valid(pcm_valid), .pcm_page_type(pcm_page_type),
        .pcm_pending(pcm_pending), .pcm_modified(pcm_modified),
        .pcm_owner_debug(pcm_owner_debug), .pcm_data(pcm_data));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single transfer; the wait on hready is cut only by the timeout
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        #1 rv = hr_q;
    endtask
    // Page cache answers late, then scrambles its data lines
    task automatic answer(input logic [8:0] f, input logic [63:0] d, input logic [31:0] a);
        while (pcm_req !== 1'b1) @(posedge hclk);
        repeat (10) @(posedge hclk);
        {pcm_in_cache, pcm_map_busy, pcm_valid, pcm_owner_debug, pcm_pending,
            pcm_modified, pcm_page_type} <= f;
        pcm_data <= d;
        pcm_ack <= 1'b1;
        cmp("addr_lo", a, pcm_addr[31:0]);
        cmp("addr_hi", 32'h1, pcm_addr[63:32]);
        @(posedge hclk);
        pcm_ack <= 1'b0;
        pcm_data <= ~d;
    endtask
    task automatic op(input logic [3:0] m, input logic [31:0] a, input logic [8:0] f,
        input logic [63:0] d, input logic [1:0] ef, input logic ec);
        logic lm;
        logic go;
        logic [1:0] c;
        logic [63:0] v;
        lm = m[0] & m[1];
        go = m[3:2] == 2'b00 && (a & (lm ? 32'h7 : 32'h3)) == 32'h0;
        c = (ef != 2'b00) ? 2'h2 : {1'b0, ec};
        bus(1, `DBR_OFF_MODE, {28'h0, m});
        bus(1, `DBR_OFF_SRC_LO, a);
        bus(1, `DBR_OFF_SRC_HI, 32'h1);
        fork
            begin
                bus(1, `DBR_OFF_CMD, 32'h4);
                if (go) begin
                    bus(0, `DBR_OFF_STATUS, 32'h0);
                    cmp("busy", 32'h1, rv);
                    bus(1, `DBR_OFF_SRC_LO, ~a);
                end
            end
            if (go) answer(f, d, a);
        join
        do bus(0, `DBR_OFF_STATUS, 32'h0); while (rv[1] !== 1'b1);
        cmp("status", {22'h0, c, 2'h0, ef, 4'h2}, rv);
        if (ef == 2'b00 && !ec) begin
            v = (f[2:0] == `DBR_PT_VERSION) ? {64{(d & ~(`DBR_VA_MASK)) != 64'h0}} : d;
            res_m = lm ? v : {res_m[63:32], v[31:0]};
        end
        bus(0, `DBR_OFF_RES_LO, 32'h0);
        cmp("res_lo", res_m[31:0], rv);
        bus(0, `DBR_OFF_RES_HI, 32'h0);
        cmp("res_hi", res_m[63:32], rv);
        bus(0, `DBR_OFF_SRC_LO, 32'h0);
        cmp("src_lo", a, rv);
        bus(1, `DBR_OFF_STATUS, 32'h2);
        bus(0, `DBR_OFF_STATUS, 32'h0);
        cmp("status_clr", {22'h0, c, 2'h0, ef, 4'h0}, rv);
    endtask
    // Hang guard, well above the fewer than a thousand cycles the run needs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        {hclk, hresetn, hsel, htrans, hwrite, pcm_ack, pcm_in_cache, pcm_map_busy} = '0;
        {pcm_valid, pcm_pending, pcm_modified, pcm_owner_debug, pcm_page_type} = '0;
        {haddr, hwdata, pcm_data, res_m, n_mismatch, total_checks, cyc} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(0, 8'(4 * i), 32'h0);
            cmp("reset_val", 32'h0, rv);
        end
        op(4'h3, 32'h1000, OKR, D0, 2'h0, 0);
        op(4'h1, 32'h1004, OKR, ~D0, 2'h0, 0);
        op(4'h3, 32'h1004, OKR, D0, 2'h1, 0);
        op(4'h0, 32'h1002, OKR, D0, 2'h1, 0);
        op(4'h7, 32'h1000, OKR, D0, 2'h1, 0);
        op(4'h3, 32'h1000, OKR ^ 9'h100, D0, 2'h2, 0);
        op(4'h3, 32'h1000, OKR | 9'h080, D0, 2'h1, 0);
        op(4'h3, 32'h1000, OKR ^ 9'h040, D0, 2'h2, 0);
        op(4'h3, 32'h1000, 9'h160, D0, 2'h2, 0);
        op(4'h3, 32'h1000, 9'h165, D0, 2'h2, 0);
        op(4'h3, TL - 32'h8, 9'h161, ~D0, 2'h0, 0);
        op(4'h3, TL, 9'h161, D0, 2'h1, 0);
        op(4'h3, 32'h1000, OKR ^ 9'h020, D0, 2'h1, 0);
        op(4'h3, 32'h1008, 9'h143, 64'h7, 2'h0, 0);
        op(4'h3, 32'h1008, 9'h143, 64'h8, 2'h0, 0);
        op(4'h0, 32'h1008, 9'h143, 64'h0, 2'h0, 0);
        op(4'h2, 32'h1008, 9'h143, 64'h8, 2'h0, 0);
        op(4'h3, 32'h1000, OKR | 9'h010, ~D0, 2'h0, 1);
        op(4'h3, 32'h1000, OKR | 9'h008, ~D0, 2'h0, 1);
        bus(1, `DBR_OFF_CMD, 32'h5);
        bus(0, `DBR_OFF_STATUS, 32'h0);
        cmp("leaf5", 32'h212, rv);
        bus(1, 8'h20, 32'hffff);
        bus(0, 8'h20, 32'h0);
        cmp("unmapped", 32'h0, rv);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `DBR_OFF_RES_HI, 32'h0);
        cmp("reset_res", 32'h0, rv);
        give_verdict();
    end
endmodule
`default_nettype wire
